// *** pcs_cfg_sideband.sv ***
// Configuration sideband port with power state machine and APB register slave.
//
// Behaviour
// - ECRC generate output mirrors control bit six.
// - ECRC check output mirrors control bit eight.
// - Link power state reported as 3-bit code.
// - Pending input sets device status pending bit.
// - Serial number input readable as serial registers.
// - PME enable, status, power state mirrored out.
// - Standby halt blocks L0s, exits to L0.
// - Deep idle halt input is accepted but has no effect.
// - Forced request overrides both halt inputs.
// - Force code selects target power state.
// - Function level reset unsupported, output low.
// - Seven-bit traffic class map to channel zero.
// - Message arrival pulses message received output.
// - Requester ID valid with message received.
// - Bus number resets zero, updates on write.
// - Device number resets zero, updates on write.
// - Function number is constant zero.
// - Active L1 requests and halts have no effect.
//////////////////////////////////////////////////////////////////
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pcs_cfg_sideband #(
   parameter int TRANS_CYCLES = pcs_pkg::TRANS_CYC
) (
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   input  wire pcs_pkg::pcs_apb_req_t apbReq,
   output pcs_pkg::pcs_apb_rsp_t      apbRsp,
   output logic                      ecrcGenEnable,
   output logic                      ecrcCheckEnable,
   output logic [2:0]                linkPowerState,
   input  wire logic                 transactionPending,
   input  wire logic [63:0]          serialNumber,
   output logic                      pmeEnable,
   output logic                      pmeStatus,
   output logic [1:0]                powerState,
   input  wire logic                 blockStandbyEntry,
   input  wire logic                 blockDeepIdleEntry,
   input  wire logic [1:0]           forcedPowerTarget,
   input  wire logic                 forcedPowerRequest,
   input  wire logic                 wakeMessageRequest,
   output logic                      funcLevelResetReceived,
   output logic [6:0]                trafficClassChannelMap,
   output logic                      messageReceived,
   output logic [15:0]               messageData,
   output logic [7:0]                busNumber,
   output logic [4:0]                deviceNumber,
   output logic [2:0]                functionNumber
);
   //////////////////////////////////////////////////////////////////
   // Bus decode.
   logic                 setup;
   logic                 access;
   logic                 wrAcc;
   logic [7:0]           addr;
   logic [31:0]          wd;
   logic                 hitAer;
   logic                 hitPm;
   logic                 hitTc;
   logic                 hitLc;
   logic                 hitMsg;
   logic                 hitCfg;
   logic                 mapped;
   logic [31:0]          rdMux;
   logic [31:0]          prdata_q;
   logic                 pslverr_q;
   logic                 aerGen_q;
   logic                 aerChk_q;
   logic [1:0]           pwrSt_q;
   logic                 pmeEn_q;
   logic                 pmeSt_q;
   logic                 pmeSt_d;
   logic [6:0]           tcMap_q;
   logic                 l0sEn_q;
   logic                 l23Req_q;
   logic                 msgVal_q;
   logic [15:0]          msgId_q;
   logic [7:0]           bus_q;
   logic [4:0]           dev_q;
   logic [2:0]           lps_q;
   logic [7:0]           timer_q;
   logic [7:0]           timer_d;
   pcs_pkg::pcs_state_t  state_q;
   pcs_pkg::pcs_state_t  state_d;
   pcs_pkg::pcs_target_t forceTgt;
   pcs_pkg::pcs_target_t autoTgt;
   pcs_pkg::pcs_target_t tgt;
   logic                 stable;
   logic                 wakeOk;
   logic                 timeUp;
   logic [2:0]           lpsCode;

   assign setup  = apbReq.psel && !apbReq.penable;
   assign access = apbReq.psel && apbReq.penable;
   assign wrAcc  = access && apbReq.pwrite;
   assign addr   = apbReq.paddr;
   assign wd     = apbReq.pwdata;
   assign hitAer = addr == pcs_pkg::REG_AER;
   assign hitPm  = addr == pcs_pkg::REG_PMCSR;
   assign hitTc  = addr == pcs_pkg::REG_TCVC;
   assign hitLc  = addr == pcs_pkg::REG_LCTRL;
   assign hitMsg = addr == pcs_pkg::REG_MSG;
   assign hitCfg = addr == pcs_pkg::REG_CFGWR;
   assign mapped = hitAer || hitPm || hitTc || hitLc || hitMsg || hitCfg
                   || addr == pcs_pkg::REG_DSTAT || addr == pcs_pkg::REG_DSN_LO
                   || addr == pcs_pkg::REG_DSN_HI || addr == pcs_pkg::REG_LSTAT;

   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (addr)
         pcs_pkg::REG_AER: begin
            rdMux[pcs_pkg::AER_GEN_BIT] = aerGen_q;
            rdMux[pcs_pkg::AER_CHK_BIT] = aerChk_q;
         end
         pcs_pkg::REG_PMCSR: begin
            rdMux[1:0]                = pwrSt_q;
            rdMux[pcs_pkg::PM_EN_BIT] = pmeEn_q;
            rdMux[pcs_pkg::PM_ST_BIT] = pmeSt_q;
         end
         pcs_pkg::REG_TCVC: rdMux[7:0] = {tcMap_q, 1'b1};
         pcs_pkg::REG_DSTAT: rdMux[pcs_pkg::TP_BIT] = transactionPending;
         pcs_pkg::REG_DSN_LO: rdMux = serialNumber[31:0];
         pcs_pkg::REG_DSN_HI: rdMux = serialNumber[63:32];
         pcs_pkg::REG_LSTAT: rdMux[2:0] = lps_q;
         pcs_pkg::REG_LCTRL: begin
            rdMux[pcs_pkg::L0S_EN_BIT]  = l0sEn_q;
            rdMux[pcs_pkg::L23_REQ_BIT] = l23Req_q;
         end
         pcs_pkg::REG_CFGWR: rdMux[12:0] = {dev_q, bus_q};
         default: rdMux = 32'h0000_0000;
      endcase
   end

   //////////////////////////////////////////////////////////////////
   // Bus response: read data captured in setup, answer in access.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q  <= apbReq.pwrite ? 32'h0000_0000 : rdMux;
         pslverr_q <= !mapped;
      end
   end

   assign apbRsp.prdata  = prdata_q;
   assign apbRsp.pready  = access;
   assign apbRsp.pslverr = access && pslverr_q;

   //////////////////////////////////////////////////////////////////
   // Configuration registers.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         aerGen_q <= 1'b0;
         aerChk_q <= 1'b0;
         pwrSt_q  <= 2'h0;
         pmeEn_q  <= 1'b0;
         tcMap_q  <= 7'h00;
         l0sEn_q  <= 1'b0;
         l23Req_q <= 1'b0;
      end else if (wrAcc) begin
         if (hitAer) begin
            aerGen_q <= wd[pcs_pkg::AER_GEN_BIT];
            aerChk_q <= wd[pcs_pkg::AER_CHK_BIT];
         end
         if (hitPm) begin
            pwrSt_q <= wd[1:0];
            pmeEn_q <= wd[pcs_pkg::PM_EN_BIT];
         end
         if (hitTc) begin
            tcMap_q <= wd[7:1];
         end
         if (hitLc) begin
            l0sEn_q  <= wd[pcs_pkg::L0S_EN_BIT];
            l23Req_q <= wd[pcs_pkg::L23_REQ_BIT];
         end
      end
   end

   // PME status is write-one-to-clear; a wake in the same cycle wins.
   assign pmeSt_d = (wakeOk && pmeEn_q)
                    || (pmeSt_q && !(wrAcc && hitPm && wd[pcs_pkg::PM_ST_BIT]));

   //////////////////////////////////////////////////////////////////
   // Link events: message arrival and type 0 configuration write.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pmeSt_q  <= 1'b0;
         msgVal_q <= 1'b0;
         msgId_q  <= 16'h0000;
         bus_q    <= pcs_pkg::BUS_RST;
         dev_q    <= pcs_pkg::DEV_RST;
      end else begin
         pmeSt_q  <= pmeSt_d;
         msgVal_q <= wrAcc && hitMsg;
         if (wrAcc && hitMsg) begin
            msgId_q <= wd[15:0];
         end
         if (wrAcc && hitCfg) begin
            bus_q <= wd[7:0];
            dev_q <= wd[pcs_pkg::DEV_LSB +: 5];
         end
      end
   end

   //////////////////////////////////////////////////////////////////
   // Power management target selection.
   always_comb begin
      unique case (forcedPowerTarget)
         pcs_pkg::FT_L0:  forceTgt = pcs_pkg::TG_L0;
         pcs_pkg::FT_L1:  forceTgt = pcs_pkg::TG_L1;
         pcs_pkg::FT_L0S: forceTgt = pcs_pkg::TG_L0S;
         default:         forceTgt = pcs_pkg::TG_L0;
      endcase
   end

   // The deep idle halt is accepted but idle entry never happens.
   assign autoTgt = l23Req_q ? pcs_pkg::TG_L23 :
                    (pwrSt_q != 2'h0) ? pcs_pkg::TG_L1 :
                    (l0sEn_q && !blockStandbyEntry && !transactionPending) ? pcs_pkg::TG_L0S :
                    pcs_pkg::TG_L0;
   assign tgt     = forcedPowerRequest ? forceTgt : autoTgt;
   assign stable  = state_q == pcs_pkg::ST_L0 || state_q == pcs_pkg::ST_L1 || state_q == pcs_pkg::ST_L23;
   assign wakeOk  = wakeMessageRequest && stable;
   assign timeUp  = timer_q == 8'h00;

   //////////////////////////////////////////////////////////////////
   // Power management state machine.
   always_comb begin
      state_d = state_q;
      timer_d = timeUp ? 8'h00 : timer_q - 8'h01;
      unique case (state_q)
         pcs_pkg::ST_L0: begin
            if (wakeOk) begin
               state_d = pcs_pkg::ST_PME;
            end else if (tgt == pcs_pkg::TG_L0S) begin
               state_d = pcs_pkg::ST_L0S;
            end else if (tgt == pcs_pkg::TG_L1) begin
               state_d = pcs_pkg::ST_TO_L1;
            end else if (tgt == pcs_pkg::TG_L23) begin
               state_d = pcs_pkg::ST_TO_L23;
            end
         end
         pcs_pkg::ST_L0S: begin
            if (tgt != pcs_pkg::TG_L0S) begin
               state_d = pcs_pkg::ST_L0;
            end
         end
         pcs_pkg::ST_TO_L1: begin
            if (timeUp) begin
               state_d = pcs_pkg::ST_L1;
            end
         end
         pcs_pkg::ST_L1: begin
            if (wakeOk) begin
               state_d = pcs_pkg::ST_PME;
            end else if (tgt != pcs_pkg::TG_L1) begin
               state_d = pcs_pkg::ST_FROM_L1;
            end
         end
         pcs_pkg::ST_FROM_L1: begin
            if (timeUp) begin
               state_d = pcs_pkg::ST_L0;
            end
         end
         pcs_pkg::ST_TO_L23: begin
            if (timeUp) begin
               state_d = pcs_pkg::ST_L23;
            end
         end
         pcs_pkg::ST_L23: begin
            if (wakeOk) begin
               state_d = pcs_pkg::ST_PME;
            end else if (tgt != pcs_pkg::TG_L23) begin
               state_d = pcs_pkg::ST_L0;
            end
         end
         pcs_pkg::ST_PME: begin
            if (timeUp) begin
               state_d = pcs_pkg::ST_L0;
            end
         end
      endcase
      if (state_d != state_q) begin
         timer_d = 8'(TRANS_CYCLES - 1);
      end
   end

   always_comb begin
      unique case (state_d)
         pcs_pkg::ST_L0:      lpsCode = pcs_pkg::LS_L0;
         pcs_pkg::ST_L0S:     lpsCode = pcs_pkg::LS_L0S;
         pcs_pkg::ST_TO_L1:   lpsCode = pcs_pkg::LS_MOVE_L1;
         pcs_pkg::ST_L1:      lpsCode = pcs_pkg::LS_L1;
         pcs_pkg::ST_FROM_L1: lpsCode = pcs_pkg::LS_MOVE_L1;
         pcs_pkg::ST_TO_L23:  lpsCode = pcs_pkg::LS_TO_L23;
         pcs_pkg::ST_L23:     lpsCode = pcs_pkg::LS_L23;
         pcs_pkg::ST_PME:     lpsCode = pcs_pkg::LS_PME;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= pcs_pkg::ST_L0;
         timer_q <= 8'h00;
         lps_q   <= pcs_pkg::LS_L0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
         lps_q   <= lpsCode;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Sideband outputs.
   assign ecrcGenEnable          = aerGen_q;
   assign ecrcCheckEnable        = aerChk_q;
   assign linkPowerState         = lps_q;
   assign pmeEnable              = pmeEn_q;
   assign pmeStatus              = pmeSt_q;
   assign powerState             = pwrSt_q;
   assign funcLevelResetReceived = 1'b0;
   assign trafficClassChannelMap = tcMap_q;
   assign messageReceived        = msgVal_q;
   assign messageData            = msgId_q;
   assign busNumber              = bus_q;
   assign deviceNumber           = dev_q;
   assign functionNumber         = pcs_pkg::FUNC_NUM;

   //////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_ecrc_gen_wr: assert property (wrAcc && hitAer |=> ecrcGenEnable == $past(wd[6]))
      else $error("ECRC generate enable not updated.");
   a_ecrc_chk_wr: assert property (wrAcc && hitAer |=> ecrcCheckEnable == $past(wd[8]))
      else $error("ECRC check enable not updated.");
   a_link_code: assert property (linkPowerState != 3'h7)
      else $error("Reserved link state code.");
   a_pending_read: assert property (setup && !apbReq.pwrite && addr == 8'h0C
      |=> prdata_q[5] == $past(transactionPending))
      else $error("Pending bit read wrong.");
   a_dsn_read: assert property (setup && !apbReq.pwrite && addr == 8'h14
      |=> prdata_q == $past(serialNumber[63:32]))
      else $error("Serial number read wrong.");
   a_pmcsr_wr: assert property (wrAcc && hitPm
      |=> powerState == $past(wd[1:0]) && pmeEnable == $past(wd[8]))
      else $error("Power control mirror wrong.");
   a_standby_block: assert property (state_q == pcs_pkg::ST_L0 && blockStandbyEntry
      && !forcedPowerRequest |=> linkPowerState != 3'h4)
      else $error("Entered standby while halted.");
   a_standby_exit: assert property (state_q == pcs_pkg::ST_L0S && blockStandbyEntry
      && !forcedPowerRequest |=> linkPowerState == 3'h0)
      else $error("Standby not left on halt.");
   a_force_prio: assert property (state_q == pcs_pkg::ST_L0 && forcedPowerRequest
      && forcedPowerTarget == 2'h2 && !wakeMessageRequest
      |=> linkPowerState == 3'h4)
      else $error("Forced standby not entered.");
   a_force_l1: assert property (state_q == pcs_pkg::ST_L0 && forcedPowerRequest
      && forcedPowerTarget == 2'h1 && !wakeMessageRequest
      |=> linkPowerState == 3'h5 ##[1:8] linkPowerState == 3'h1)
      else $error("Forced L1 not reached.");
   a_deep_idle: assert property (state_q == pcs_pkg::ST_L0 && forcedPowerRequest
      && forcedPowerTarget == 2'h3 && !wakeMessageRequest
      |=> linkPowerState == 3'h0)
      else $error("Active L1 force had an effect.");
   a_msg_pulse: assert property (wrAcc && hitMsg
      |=> messageReceived && messageData == $past(wd[15:0]))
      else $error("Message notification wrong.");
   a_msg_single: assert property (messageReceived && !$past(wrAcc && hitMsg)
      |-> 1'b0)
      else $error("Spurious message pulse.");
   a_bus_dev_wr: assert property (wrAcc && hitCfg
      |=> busNumber == $past(wd[7:0]) && deviceNumber == $past(wd[12:8]))
      else $error("Bus or device number not updated.");
   a_fixed_ids: assert property (functionNumber == 3'h0 && !funcLevelResetReceived)
      else $error("Fixed outputs changed.");

   c_standby: cover property (linkPowerState == 3'h0 ##1 linkPowerState == 3'h4);
   c_reach_l1: cover property (linkPowerState == 3'h5 ##[1:8] linkPowerState == 3'h1);
   c_wake: cover property (wakeOk ##1 linkPowerState == 3'h3);
   c_message: cover property (messageReceived);
endmodule : pcs_cfg_sideband

// *** pcs_pkg.sv ***
// Constants, types and register map of the configuration sideband port.
package pcs_pkg;
   localparam int         ADDR_W      = 8;
   localparam int         DATA_W      = 32;
   localparam logic [7:0] REG_AER     = 8'h00;
   localparam logic [7:0] REG_PMCSR   = 8'h04;
   localparam logic [7:0] REG_TCVC    = 8'h08;
   localparam logic [7:0] REG_DSTAT   = 8'h0C;
   localparam logic [7:0] REG_DSN_LO  = 8'h10;
   localparam logic [7:0] REG_DSN_HI  = 8'h14;
   localparam logic [7:0] REG_LSTAT   = 8'h18;
   localparam logic [7:0] REG_LCTRL   = 8'h1C;
   localparam logic [7:0] REG_MSG     = 8'h20;
   localparam logic [7:0] REG_CFGWR   = 8'h24;
   localparam int         AER_GEN_BIT = 6;
   localparam int         AER_CHK_BIT = 8;
   localparam int         PM_EN_BIT   = 8;
   localparam int         PM_ST_BIT   = 15;
   localparam int         TP_BIT      = 5;
   localparam int         L0S_EN_BIT  = 0;
   localparam int         L23_REQ_BIT = 1;
   localparam int         DEV_LSB     = 8;
   localparam logic [2:0] LS_L0       = 3'h0;
   localparam logic [2:0] LS_L1       = 3'h1;
   localparam logic [2:0] LS_L23      = 3'h2;
   localparam logic [2:0] LS_PME      = 3'h3;
   localparam logic [2:0] LS_L0S      = 3'h4;
   localparam logic [2:0] LS_MOVE_L1  = 3'h5;
   localparam logic [2:0] LS_TO_L23   = 3'h6;
   localparam logic [1:0] FT_L0       = 2'h0;
   localparam logic [1:0] FT_L1       = 2'h1;
   localparam logic [1:0] FT_L0S      = 2'h2;
   localparam logic [2:0] FUNC_NUM    = 3'h0;
   localparam logic [7:0] BUS_RST     = 8'h00;
   localparam logic [4:0] DEV_RST     = 5'h00;
   localparam int         CLK_MHZ     = 100;
   localparam int         TRANS_NS    = 40;
   localparam int         TRANS_CYC   = (TRANS_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {TG_L0, TG_L0S, TG_L1, TG_L23} pcs_target_t;
   typedef enum logic [2:0] {ST_L0, ST_L0S, ST_TO_L1, ST_L1, ST_FROM_L1, ST_TO_L23, ST_L23, ST_PME} pcs_state_t;
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } pcs_apb_req_t;
   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic              pready;
      logic              pslverr;
   } pcs_apb_rsp_t;
endpackage : pcs_pkg

// *** pcs_user_model.sv ***
// Behavioural model of the user application on the far side of the sideband port.
`timescale 1ns/1ps
module pcs_user_model (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [2:0]  linkPowerState,
   input  wire logic [7:0]  busNumber,
   input  wire logic [4:0]  deviceNumber,
   input  wire logic [2:0]  functionNumber,
   input  wire logic        messageReceived,
   input  wire logic [15:0] messageData,
   input  wire logic        forceGo,
   input  wire logic [1:0]  forceCode,
   input  wire logic        wakeGo,
   output logic             forcedPowerRequest,
   output logic [1:0]       forcedPowerTarget,
   output logic             wakeMessageRequest,
   output logic [15:0]      requesterId,
   output logic [15:0]      capturedId
);
   logic        req_q;
   logic [1:0]  code_q;
   logic        wake_q;
   logic [15:0] id_q;
   logic [2:0]  want;
   logic        stable;
   assign want   = (code_q == 2'h1) ? 3'h1 : ((code_q == 2'h2) ? 3'h4 : 3'h0);
   assign stable = (linkPowerState == 3'h0) || (linkPowerState == 3'h1) || (linkPowerState == 3'h2);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         req_q  <= 1'b0;
         code_q <= 2'h0;
         wake_q <= 1'b0;
         id_q   <= 16'h0000;
      end else begin
         req_q  <= forceGo | (req_q & (linkPowerState != want));
         code_q <= forceGo ? forceCode : code_q;
         wake_q <= wakeGo & stable & ~wake_q;
         id_q   <= messageReceived ? messageData : id_q;
      end
   end
   assign forcedPowerRequest = req_q;
   assign forcedPowerTarget  = code_q;
   assign wakeMessageRequest = wake_q;
   assign capturedId         = id_q;
   assign requesterId        = {busNumber, deviceNumber, functionNumber};
endmodule : pcs_user_model

// *** tb_pcs_cfg_sideband.sv ***
// Self-checking testbench of the configuration sideband port.
`timescale 1ns/1ps
module tb_pcs_cfg_sideband;
   logic                  ref_clk, reset, ecrcGenEnable, ecrcCheckEnable, transactionPending;
   logic                  pmeEnable, pmeStatus, blockStandbyEntry, blockDeepIdleEntry, forcedPowerRequest;
   logic                  wakeMessageRequest, funcLevelResetReceived, messageReceived, forceGo, wakeGo, rerr;
   logic [1:0]            powerState, forcedPowerTarget, forceCode;
   logic [2:0]            linkPowerState, functionNumber;
   logic [4:0]            deviceNumber;
   logic [6:0]            trafficClassChannelMap;
   logic [7:0]            busNumber;
   logic [15:0]           messageData, requesterId, capturedId;
   logic [31:0]           rdata;
   logic [63:0]           serialNumber;
   pcs_pkg::pcs_apb_req_t apbReq;
   pcs_pkg::pcs_apb_rsp_t apbRsp;
   int                    failures, numChecks;
   pcs_cfg_sideband #(.TRANS_CYCLES(4)) dut_u (.ref_clk, .reset, .apbReq, .apbRsp, .ecrcGenEnable,
      .ecrcCheckEnable, .linkPowerState, .transactionPending, .serialNumber, .pmeEnable, .pmeStatus,
      .powerState, .blockStandbyEntry, .blockDeepIdleEntry, .forcedPowerTarget, .forcedPowerRequest,
      .wakeMessageRequest, .funcLevelResetReceived, .trafficClassChannelMap, .messageReceived,
      .messageData, .busNumber, .deviceNumber, .functionNumber);
   pcs_user_model user_u (.ref_clk, .reset, .linkPowerState, .busNumber, .deviceNumber, .functionNumber,
      .messageReceived, .messageData, .forceGo, .forceCode, .wakeGo, .forcedPowerRequest,
      .forcedPowerTarget, .wakeMessageRequest, .requesterId, .capturedId);
   //////////////////////////////
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] x);
      numChecks++;
      if (s !== x) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge ref_clk);
      apbReq.penable <= 1'b1;
      @(posedge ref_clk);
      while (apbRsp.pready !== 1'b1) @(posedge ref_clk);
      rdata = apbRsp.prdata;
      rerr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask : apb
   task automatic waitLps(input logic [2:0] v);
      int i;
      i = 0;
      while (linkPowerState !== v && i < 40) begin
         @(posedge ref_clk);
         i++;
      end
      chk("linkPowerState", linkPowerState, v);
   endtask : waitLps
   task automatic report_and_stop();
      $display("Checks %0d failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop
   //////////////////////////////
   task automatic t_reset();
      chk("busNumber", busNumber, 8'h00);
      chk("deviceNumber", deviceNumber, 5'h00);
      chk("functionNumber", functionNumber, 3'h0);
      chk("funcLevelReset", funcLevelResetReceived, 1'b0);
      chk("messageReceived", messageReceived, 1'b0);
   endtask : t_reset
   task automatic t_regs();
      apb(1'b1, pcs_pkg::REG_AER, 32'h0000_0040);
      cyc(1);
      chk("ecrcGen", {ecrcGenEnable, ecrcCheckEnable}, 2'h2);
      apb(1'b1, pcs_pkg::REG_AER, 32'h0000_0100);
      cyc(1);
      chk("ecrcChk", {ecrcGenEnable, ecrcCheckEnable}, 2'h1);
      apb(1'b1, pcs_pkg::REG_PMCSR, 32'h0000_0102);
      cyc(1);
      chk("pmcsr", {pmeEnable, pmeStatus, powerState}, 4'hA);
      apb(1'b1, pcs_pkg::REG_PMCSR, 32'h0000_0100);
      waitLps(3'h0);
      apb(1'b1, pcs_pkg::REG_TCVC, 32'h0000_00AA);
      cyc(1);
      chk("tcMap", trafficClassChannelMap, 7'h55);
   endtask : t_regs
   task automatic t_reads();
      transactionPending <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, pcs_pkg::REG_DSTAT, 32'h0);
      chk("pendSet", rdata[5], 1'b1);
      transactionPending <= 1'b0;
      @(posedge ref_clk);
      apb(1'b0, pcs_pkg::REG_DSTAT, 32'h0);
      chk("pendClr", rdata[5], 1'b0);
      apb(1'b0, pcs_pkg::REG_DSN_LO, 32'h0);
      chk("dsnLo", rdata, serialNumber[31:0]);
      cyc(1);
      apb(1'b0, pcs_pkg::REG_DSN_HI, 32'h0);
      chk("dsnHi", rdata, serialNumber[63:32]);
      cyc(1);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", rerr, 1'b1);
   endtask : t_reads
   task automatic t_link();
      apb(1'b1, pcs_pkg::REG_MSG, 32'h0000_BEEF);
      cyc(1);
      chk("msgRx", {messageReceived, messageData}, 17'h1BEEF);
      cyc(1);
      chk("msgPulse", messageReceived, 1'b0);
      chk("msgId", capturedId, 16'hBEEF);
      apb(1'b1, pcs_pkg::REG_CFGWR, 32'h0000_0A5C);
      cyc(1);
      chk("busDev", {busNumber, deviceNumber}, 13'h0B8A);
      chk("reqId", requesterId, 16'h5C50);
   endtask : t_link
   task automatic t_force();
      logic [2:0] expect_[4];
      expect_ = '{3'h0, 3'h1, 3'h4, 3'h0};
      blockStandbyEntry <= 1'b1;
      blockDeepIdleEntry <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         forceCode <= k[1:0];
         forceGo <= 1'b1;
         if (k == 1) waitLps(3'h5);
         cyc(8);
         waitLps(expect_[k]);
         forceGo <= 1'b0;
         cyc(1);
         waitLps(3'h0);
      end
      blockStandbyEntry <= 1'b0;
      blockDeepIdleEntry <= 1'b0;
   endtask : t_force
   task automatic t_l0s();
      apb(1'b1, pcs_pkg::REG_LCTRL, 32'h0000_0001);
      waitLps(3'h4);
      blockDeepIdleEntry <= 1'b1;
      cyc(3);
      chk("deepIdle", linkPowerState, 3'h4);
      blockStandbyEntry <= 1'b1;
      cyc(3);
      chk("standby", linkPowerState, 3'h0);
      apb(1'b1, pcs_pkg::REG_LCTRL, 32'h0);
      blockStandbyEntry <= 1'b0;
      blockDeepIdleEntry <= 1'b0;
   endtask : t_l0s
   task automatic t_wake();
      wakeGo <= 1'b1;
      @(posedge ref_clk);
      wakeGo <= 1'b0;
      waitLps(3'h3);
      cyc(6);
      chk("wakeEnd", {linkPowerState, pmeStatus}, 4'h1);
      apb(1'b1, pcs_pkg::REG_PMCSR, 32'h0000_8100);
      cyc(1);
      chk("pmeClear", {pmeEnable, pmeStatus}, 2'h2);
   endtask : t_wake
   task automatic t_rerun();
      reset <= 1'b1;
      cyc(2);
      reset <= 1'b0;
      cyc(1);
      chk("rerunIds", {busNumber, deviceNumber, pmeEnable, pmeStatus}, 15'h0000);
      chk("rerunLps", {linkPowerState, messageData}, 19'h00000);
      chk("rerunEcrc", {ecrcGenEnable, ecrcCheckEnable, trafficClassChannelMap}, 9'h000);
   endtask : t_rerun
   //////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      report_and_stop();
   end
   initial begin
      failures = 0;
      numChecks = 0;
      reset = 1'b1;
      apbReq = '0;
      {transactionPending, blockStandbyEntry, blockDeepIdleEntry, forceGo, wakeGo, forceCode} = '0;
      serialNumber = 64'h0123_4567_89AB_CDEF;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_regs();
      t_reads();
      t_link();
      t_force();
      t_l0s();
      t_wake();
      t_rerun();
      report_and_stop();
   end
endmodule : tb_pcs_cfg_sideband
